// *** common/gpdev_pkg.sv ***
// Package for the instrument-side bus interface: command codes, field layouts,
// timing counts and the carrier structs shared by the core and its helpers.
// Assumes a single 40 MHz clock domain.
package gpdev_pkg;

  // Clock rate and derived counts
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  // Settle time from data on the bus to data valid asserted, in ns
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);

  // Byte and address layout
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 5;
  localparam int GROUP_MSB = 6;
  localparam int GROUP_LSB = 5;
  localparam int SRQ_BIT = 6;
  localparam int FIFO_DEPTH = 4;

  // Command group codes in bits 6:5 while attention is true
  localparam logic [1:0] GRP_ACG = 2'h0;
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;

  // Address that means unlisten or untalk
  localparam logic [4:0] ADDR_UN = 5'h1f;

  // Addressed commands
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  // Universal commands
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;

  // Trigger mode codes; the two bus-triggerable ones named
  localparam logic [2:0] TRIG_BUS_A = 3'h2;
  localparam logic [2:0] TRIG_BUS_B = 3'h3;

  // Control lines sampled from the bus, active high after inversion
  typedef struct packed {
    logic atn;
    logic ren;
    logic ifc;
    logic dav;
    logic nrfd;
    logic ndac;
  } gpdev_ctl_t;

  // One received data byte with its end flag
  typedef struct packed {
    logic eoi;
    logic [7:0] data;
  } gpdev_word_t;

  // Interface state shown to the instrument
  typedef struct packed {
    logic remote;
    logic lockout;
    logic talk;
    logic listen;
    logic spoll;
  } gpdev_stat_t;

endpackage : gpdev_pkg

// *** core/gpdev_sync.sv ***
// Two-flop synchroniser for a bundle of asynchronous bus lines.
// Assumes the lines are quasi-static compared to the 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module gpdev_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Lines
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage read only by the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // gpdev_sync
`default_nettype wire

// *** core/gpdev_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Read data come straight from a register; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gpdev_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic [WIDTH-1:0] out_ff, nxt_out;
  logic out_v_ff, nxt_out_v;
  logic push, pop, load;

  // Output register refills when empty or consumed
  always_comb begin
    load = !out_v_ff || i_out_ready;
    push = i_in_valid && o_in_ready;
    pop = load && (cnt_ff != '0);
    nxt_wr = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_out = pop ? mem_ff[rd_ff] : out_ff;
    nxt_out_v = load ? pop : out_v_ff;
    if (i_flush) begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
      nxt_out_v = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      out_ff <= '0;
      out_v_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      out_v_ff <= nxt_out_v;
    end
  end

  // Storage has no reset; contents are gated by the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // Output register counts as a slot, so DEPTH words in all, not one more
  assign o_in_ready = ((cnt_ff + (AW+1)'(out_v_ff)) < (AW+1)'(DEPTH)) && !i_flush;
  assign o_out_valid = out_v_ff;
  assign o_out_data = out_ff;
endmodule // gpdev_fifo
`default_nettype wire

// *** core/gpdev_core.sv ***
// Instrument-side bus interface: handshakes, talker, listener, service
// request, remote/local, device clear and device trigger.
// Assumes open-collector pins resolved outside; all bus lines arrive
// active high (true = asserted) and unsynchronised.
// Function
// - Talk only when addressed or talk-only
// - Listen to data only after own address
// - Other talk-address in talk group unaddresses talker
// - Own talk address unaddresses the listener
// - Serial poll returns status byte, not data
// - No parallel poll response at all
// - No controller, no secondary address decode
// - Full source and acceptor handshakes
// - Assert service request line on request
// - Remote only when addressed while remote-enabled
// - Interface clear: local, talker and listener idle
// - Local lockout disables front panel return
// - Device clear reinitializes to defaults
// - Trigger works only in bus trigger modes
// - Lockout accepted only with remote enable
// - Only remote enable false cancels lockout
// - Go-to-local leaves remote, lamp off
`timescale 1ns/1ps
`default_nettype none
module gpdev_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Configuration
  input wire logic [4:0] i_my_addr,
  input wire logic i_talk_only,
  input wire logic [2:0] i_trig_mode,
  // Bus control lines, asserted high
  input wire gpdev_pkg::gpdev_ctl_t i_bus_ctl,
  input wire logic i_bus_eoi,
  input wire logic [7:0] i_bus_dio,
  // Bus drivers: value and enable
  output logic [7:0] o_dio_out,
  output logic o_dio_oe,
  output logic o_eoi_oe,
  output logic o_dav_oe,
  output logic o_nrfd_oe,
  output logic o_ndac_oe,
  output logic o_srq_oe,
  // Talker source from instrument
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  input wire logic [7:0] i_status_byte,
  input wire logic i_rsv,
  // Listener data to instrument
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_eoi,
  input wire logic i_rx_ready,
  // Events and state
  output logic o_trigger,
  output logic o_dev_clear,
  output logic o_panel_lock,
  output gpdev_pkg::gpdev_stat_t o_stat
);
  typedef enum {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_WAIT_DAC, SH_DONE} gpdev_sh_t;
  typedef enum {AH_READY, AH_TAKE, AH_WAIT_DROP} gpdev_ah_t;

  gpdev_pkg::gpdev_ctl_t ctl;
  logic [8:0] dat_s;
  gpdev_pkg::gpdev_word_t fin, fout;
  logic fin_ready, fout_valid, fifo_flush;

  // All bus inputs cross into the clock domain
  gpdev_sync #(.W(6)) u_sync_ctl (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(i_bus_ctl),
    .o_sync(ctl)
  );
  gpdev_sync #(.W(9)) u_sync_dat (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({i_bus_eoi, i_bus_dio}),
    .o_sync(dat_s)
  );

  // State registers
  gpdev_sh_t sh_ff, nxt_sh;
  gpdev_ah_t ah_ff, nxt_ah;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] dio_ff, nxt_dio;
  logic eoi_ff, nxt_eoi;
  logic dio_oe_ff, nxt_dio_oe;
  logic dav_ff, nxt_dav;
  logic nrfd_ff, nxt_nrfd;
  logic ndac_ff, nxt_ndac;
  logic srq_ff, nxt_srq;
  logic talk_ff, nxt_talk;
  logic listen_ff, nxt_listen;
  logic spe_ff, nxt_spe;
  logic remote_ff, nxt_remote;
  logic lock_ff, nxt_lock;
  logic trig_ff, nxt_trig;
  logic clr_ff, nxt_clr;
  logic sb_sent_ff, nxt_sb_sent;
  logic tx_rdy_ff, nxt_tx_rdy;

  // Decode of the byte latched by the acceptor
  logic [7:0] cmd;
  logic [1:0] grp;
  logic [4:0] adr;
  logic take, is_cmd, is_data;
  logic my_la, my_ta, unl, unt, other_ta;
  logic talking, src_ok;
  logic [8:0] src_word;

  always_comb begin
    cmd = dat_s[7:0];
    grp = cmd[gpdev_pkg::GROUP_MSB:gpdev_pkg::GROUP_LSB];
    adr = cmd[gpdev_pkg::ADDR_W-1:0];
    take = (ah_ff == AH_TAKE);
    is_cmd = take && ctl.atn;
    is_data = take && !ctl.atn && listen_ff;
    // Only primary addresses decode; secondaries fall through
    my_la = is_cmd && grp == gpdev_pkg::GRP_LAG && adr == i_my_addr;
    my_ta = is_cmd && grp == gpdev_pkg::GRP_TAG && adr == i_my_addr;
    unl = is_cmd && grp == gpdev_pkg::GRP_LAG && adr == gpdev_pkg::ADDR_UN;
    unt = is_cmd && grp == gpdev_pkg::GRP_TAG && adr == gpdev_pkg::ADDR_UN;
    other_ta = is_cmd && grp == gpdev_pkg::GRP_TAG && adr != i_my_addr;
    talking = (talk_ff || i_talk_only) && !ctl.atn && !ctl.ifc;
    // Serial poll sends the status byte once in place of data
    src_ok = spe_ff ? !sb_sent_ff : fout_valid;
    src_word = spe_ff ? {1'b1, i_status_byte[7:gpdev_pkg::SRQ_BIT+1], srq_ff,
                         i_status_byte[gpdev_pkg::SRQ_BIT-1:0]} : fout;
  end

  // Addressing, remote/local, serial poll and device events
  always_comb begin
    nxt_talk = talk_ff;
    nxt_listen = listen_ff;
    nxt_spe = spe_ff;
    nxt_remote = remote_ff;
    nxt_lock = lock_ff;
    nxt_trig = 1'b0;
    nxt_clr = 1'b0;
    nxt_srq = i_rsv && !(spe_ff && sb_sent_ff && talk_ff);
    if (my_la) begin
      nxt_listen = 1'b1;
      if (ctl.ren) nxt_remote = 1'b1;
    end
    if (unl) nxt_listen = 1'b0;
    if (my_ta) nxt_talk = 1'b1;
    if (other_ta) nxt_talk = 1'b0;
    if (is_cmd && grp == gpdev_pkg::GRP_TAG && adr != i_my_addr && !unt) begin
      nxt_listen = nxt_listen;
    end
    // Listener drops when our own talk address arrives
    if (my_ta) nxt_listen = 1'b0;
    if (my_la) nxt_talk = 1'b0;
    if (unt) nxt_talk = 1'b0;
    if (is_cmd) begin
      unique case (cmd[6:0])
        gpdev_pkg::CMD_SPE: nxt_spe = 1'b1;
        gpdev_pkg::CMD_SPD: nxt_spe = 1'b0;
        gpdev_pkg::CMD_LLO: if (ctl.ren) nxt_lock = 1'b1;
        gpdev_pkg::CMD_DCL: nxt_clr = 1'b1;
        gpdev_pkg::CMD_GTL: if (listen_ff) nxt_remote = 1'b0;
        gpdev_pkg::CMD_SDC: if (listen_ff) nxt_clr = 1'b1;
        gpdev_pkg::CMD_GET:
          if (listen_ff && (i_trig_mode == gpdev_pkg::TRIG_BUS_A ||
                            i_trig_mode == gpdev_pkg::TRIG_BUS_B)) begin
            nxt_trig = 1'b1;
          end
        default: ;
      endcase
    end
    // Parallel poll commands fall into default and are ignored
    if (!ctl.ren) begin
      nxt_remote = 1'b0;
      nxt_lock = 1'b0;
    end
    if (ctl.ifc) begin
      nxt_talk = 1'b0;
      nxt_listen = 1'b0;
      nxt_spe = 1'b0;
      nxt_remote = 1'b0;
    end
  end

  // Source handshake
  always_comb begin
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_dio = dio_ff;
    nxt_eoi = eoi_ff;
    nxt_dio_oe = dio_oe_ff;
    nxt_dav = dav_ff;
    nxt_sb_sent = sb_sent_ff;
    nxt_tx_rdy = 1'b0;
    if (!spe_ff) nxt_sb_sent = 1'b0;
    unique case (sh_ff)
      SH_IDLE: begin
        nxt_dav = 1'b0;
        nxt_dio_oe = 1'b0;
        nxt_eoi = 1'b0;
        if (talking && src_ok) begin
          nxt_dio = src_word[7:0];
          nxt_eoi = src_word[8];
          nxt_dio_oe = 1'b1;
          nxt_cnt = gpdev_pkg::SETTLE_CNT;
          nxt_sh = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        // Data settle before data valid, per the source timing
        if (cnt_ff != 4'h0) nxt_cnt = cnt_ff - 4'h1;
        else nxt_sh = SH_WAIT_RFD;
      end
      SH_WAIT_RFD: begin
        if (!ctl.nrfd) begin
          nxt_dav = 1'b1;
          nxt_sh = SH_WAIT_DAC;
        end
      end
      SH_WAIT_DAC: begin
        if (!ctl.ndac) begin
          nxt_dav = 1'b0;
          nxt_tx_rdy = !spe_ff;
          if (spe_ff) nxt_sb_sent = 1'b1;
          nxt_sh = SH_DONE;
        end
      end
      SH_DONE: begin
        nxt_dio_oe = 1'b0;
        nxt_eoi = 1'b0;
        nxt_sh = SH_IDLE;
      end
    endcase
    // Attention or clear aborts a source cycle at once
    if (!talking) begin
      nxt_sh = SH_IDLE;
      nxt_dav = 1'b0;
      nxt_dio_oe = 1'b0;
      nxt_eoi = 1'b0;
      nxt_tx_rdy = 1'b0;
    end
  end

  // Acceptor handshake
  always_comb begin
    nxt_ah = ah_ff;
    nxt_nrfd = nrfd_ff;
    nxt_ndac = ndac_ff;
    unique case (ah_ff)
      AH_READY: begin
        // Hold off data when the receive buffer is full
        nxt_nrfd = !(ctl.atn || (listen_ff && fin_ready));
        nxt_ndac = 1'b1;
        if (ctl.dav && !nrfd_ff) begin
          nxt_nrfd = 1'b1;
          nxt_ah = AH_TAKE;
        end
      end
      AH_TAKE: begin
        nxt_ndac = 1'b0;
        nxt_ah = AH_WAIT_DROP;
      end
      AH_WAIT_DROP: begin
        if (!ctl.dav) begin
          nxt_ndac = 1'b1;
          nxt_ah = AH_READY;
        end
      end
    endcase
    // Acceptor only runs under attention or while listening
    if (!(ctl.atn || listen_ff) || ctl.ifc) begin
      nxt_ah = AH_READY;
      nxt_nrfd = 1'b0;
      nxt_ndac = 1'b0;
    end
  end

  assign fin = '{eoi: dat_s[8], data: dat_s[7:0]};
  assign fifo_flush = clr_ff || ctl.ifc;

  // Received data pass a small buffer toward the instrument
  gpdev_fifo #(.WIDTH(9), .DEPTH(gpdev_pkg::FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_flush(fifo_flush),
    .i_in_valid(is_data),
    .o_in_ready(fin_ready),
    .i_in_data(fin),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data({o_rx_eoi, o_rx_data})
  );

  // Outgoing data buffer; drained by the source handshake
  gpdev_fifo #(.WIDTH(9), .DEPTH(gpdev_pkg::FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_flush(clr_ff),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data({i_tx_last, i_tx_data}),
    .o_out_valid(fout_valid),
    .i_out_ready(tx_rdy_ff),
    .o_out_data(fout)
  );

  // Register every group
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_ff <= SH_IDLE;
      ah_ff <= AH_READY;
      cnt_ff <= 4'h0;
      dio_ff <= 8'h00;
      eoi_ff <= 1'b0;
      dio_oe_ff <= 1'b0;
      dav_ff <= 1'b0;
      nrfd_ff <= 1'b0;
      ndac_ff <= 1'b0;
      srq_ff <= 1'b0;
      talk_ff <= 1'b0;
      listen_ff <= 1'b0;
      spe_ff <= 1'b0;
      remote_ff <= 1'b0;
      lock_ff <= 1'b0;
      trig_ff <= 1'b0;
      clr_ff <= 1'b0;
      sb_sent_ff <= 1'b0;
      tx_rdy_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      ah_ff <= nxt_ah;
      cnt_ff <= nxt_cnt;
      dio_ff <= nxt_dio;
      eoi_ff <= nxt_eoi;
      dio_oe_ff <= nxt_dio_oe;
      dav_ff <= nxt_dav;
      nrfd_ff <= nxt_nrfd;
      ndac_ff <= nxt_ndac;
      srq_ff <= nxt_srq;
      talk_ff <= nxt_talk;
      listen_ff <= nxt_listen;
      spe_ff <= nxt_spe;
      remote_ff <= nxt_remote;
      lock_ff <= nxt_lock;
      trig_ff <= nxt_trig;
      clr_ff <= nxt_clr;
      sb_sent_ff <= nxt_sb_sent;
      tx_rdy_ff <= nxt_tx_rdy;
    end
  end

  // Drivers; the parallel poll path does not exist
  assign o_dio_out = dio_ff;
  assign o_dio_oe = dio_oe_ff;
  assign o_eoi_oe = eoi_ff;                                      // Cleared with data enable
  assign o_dav_oe = dav_ff;
  assign o_nrfd_oe = nrfd_ff;
  assign o_ndac_oe = ndac_ff;
  assign o_srq_oe = srq_ff;
  assign o_trigger = trig_ff;
  assign o_dev_clear = clr_ff;
  assign o_panel_lock = lock_ff;
  assign o_stat = '{remote: remote_ff, lockout: lock_ff, talk: talk_ff,
                    listen: listen_ff, spoll: spe_ff};
endmodule // gpdev_core
`default_nettype wire

// *** sim/gpdev_core_sva.sv ***
// Checker for the bus interface core; sees only the core's ports.
// Assumes one clock domain and bus lines given active high.
`timescale 1ns/1ps
`default_nettype none
module gpdev_core_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Inputs watched
  input wire logic i_talk_only,
  input wire logic [2:0] i_trig_mode,
  input wire gpdev_pkg::gpdev_ctl_t i_bus_ctl,
  input wire logic i_rsv,
  // Outputs watched
  input wire logic o_dio_oe,
  input wire logic o_dav_oe,
  input wire logic o_nrfd_oe,
  input wire logic o_ndac_oe,
  input wire logic o_srq_oe,
  input wire logic o_trigger,
  input wire logic o_panel_lock,
  input wire gpdev_pkg::gpdev_stat_t o_stat
);
  // Single domain, so one clock and one reset for all
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Launch may trail the unaddressing by one cycle
  a_talk_gate: assert property (
    $rose(o_dio_oe) |-> o_stat.talk || i_talk_only || $past(o_stat.talk))
    else $error("data lines driven while not talking");
  // Sync delay plus one edge to abort
  a_atn_quiet: assert property (
    i_bus_ctl.atn [*5] |-> !o_dio_oe)
    else $error("data lines driven under attention");
  a_remote_ren: assert property (
    $rose(o_stat.remote) |-> i_bus_ctl.ren && o_stat.listen)
    else $error("remote entered without enable and listen");
  a_ren_cancel: assert property (
    $fell(i_bus_ctl.ren) |-> ##[1:5] !o_stat.remote && !o_stat.lockout)
    else $error("remote or lockout kept after enable dropped");
  a_lock_ren: assert property (
    $rose(o_stat.lockout) |-> i_bus_ctl.ren ##[0:1] o_panel_lock)
    else $error("lockout without enable or panel not locked");
  a_ifc_idle: assert property (
    i_bus_ctl.ifc [*5] |-> !(o_stat.talk || o_stat.listen || o_stat.remote))
    else $error("not idle and local under interface clear");
  a_trig_mode: assert property (
    o_trigger |-> (i_trig_mode == gpdev_pkg::TRIG_BUS_A
      || i_trig_mode == gpdev_pkg::TRIG_BUS_B) ##1 !o_trigger)
    else $error("trigger in wrong mode or longer than a pulse");
  a_dav_settle: assert property (
    $rose(o_dav_oe) |-> $past(o_dio_oe, 4) && o_dio_oe)
    else $error("data valid before data settled");
  a_srq_req: assert property (
    $rose(i_rsv) && !o_stat.spoll |-> ##[1:4] o_srq_oe)
    else $error("service request line not asserted");
  a_idle_acc: assert property (
    (!i_bus_ctl.atn && !o_stat.listen) [*4] |-> !o_nrfd_oe && !o_ndac_oe)
    else $error("acceptor active while not listening");
endmodule // gpdev_core_sva
`default_nettype wire

// *** sim/gpdev_ctrl.sv ***
// Bus controller model: attention, remote enable, clear and handshakes.
// Assumes the bench wire-ORs its lines with the core's; 1 = asserted.
`timescale 1ns/1ps
`default_nettype none
module gpdev_ctrl (
  // Clock
  input wire logic i_clk,
  // Resolved bus lines
  input wire logic i_dav,
  input wire logic i_nrfd,
  input wire logic i_ndac,
  input wire logic i_eoi,
  input wire logic [7:0] i_dio,
  // Controller drives
  output logic o_atn,
  output logic o_ren,
  output logic o_ifc,
  output logic o_dav,
  output logic o_nrfd,
  output logic o_ndac,
  output logic o_eoi,
  output logic [7:0] o_dio
);
  // Released lines read false through the pull-ups
  initial begin
    {o_atn, o_ren, o_ifc, o_dav, o_nrfd, o_ndac, o_eoi} = 7'h00;
    o_dio = 8'h00;
  end

  // Remote enable must come before the listen address
  task automatic set_ren(input logic v);
    @(posedge i_clk) #1;
    o_ren = v;
  endtask

  // Source one byte; gives up if ready-for-data stays false
  task automatic send(input logic [7:0] b, input logic a, input logic e, output logic ok);
    int n = 0;
    @(posedge i_clk) #1;
    {o_atn, o_nrfd, o_ndac, o_eoi} = {a, 2'h0, e};
    o_dio = b;
    repeat (4) @(posedge i_clk);
    while (i_nrfd && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    ok = !i_nrfd;
    if (ok) begin
      #1 o_dav = 1'h1;
      while (i_ndac && n < 400) begin
        @(posedge i_clk);
        n++;
      end
      #1 {o_dav, o_eoi} = 2'h0;
      o_dio = 8'h00;
    end
  endtask

  // Accept one byte with its end flag; drops attention first
  task automatic recv(output logic [8:0] w);
    int n = 0;
    @(posedge i_clk) #1;
    {o_atn, o_ndac, o_nrfd} = 3'h3;
    @(posedge i_clk) #1;
    o_nrfd = 1'h0;
    while (!i_dav && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    w = {i_eoi, i_dio};
    #1 {o_nrfd, o_ndac} = 2'h2;
    while (i_dav && n < 800) begin
      @(posedge i_clk);
      n++;
    end
    #1 o_ndac = 1'h1;
  endtask

  // Interface clear held for the minimum of 100 us
  task automatic clear_bus();
    @(posedge i_clk) #1;
    o_ifc = 1'h1;
    repeat (4000) @(posedge i_clk);
    #1 o_ifc = 1'h0;
  endtask
endmodule // gpdev_ctrl
`default_nettype wire

// *** sim/gpdev_test.sv ***
// Self-checking bench for the bus interface core with a controller model.
// Assumes package, synchroniser, FIFO and core are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gpdev_test;
  localparam logic [4:0] MY = 5'h0a;
  typedef struct packed {
    logic ren;
    logic [7:0] cmd;
    logic [4:0] st;
    logic clr;
  } gpdev_row_t;
  // Enable, byte under attention, state after, clear pulses
  localparam gpdev_row_t ROWS [19] = '{
    {1'h1, 8'h3f, 5'h00, 1'h0}, {1'h1, 8'h2a, 5'h12, 1'h0}, {1'h1, 8'h2b, 5'h12, 1'h0},
    {1'h1, 8'h11, 5'h1a, 1'h0}, {1'h1, 8'h01, 5'h0a, 1'h0}, {1'h1, 8'h4a, 5'h0c, 1'h0},
    {1'h1, 8'h2a, 5'h1a, 1'h0}, {1'h1, 8'h4a, 5'h1c, 1'h0}, {1'h1, 8'h4b, 5'h18, 1'h0},
    {1'h1, 8'h18, 5'h19, 1'h0}, {1'h1, 8'h19, 5'h18, 1'h0}, {1'h1, 8'h2a, 5'h1a, 1'h0},
    {1'h1, 8'h04, 5'h1a, 1'h1}, {1'h1, 8'h14, 5'h1a, 1'h1}, {1'h0, 8'h3f, 5'h00, 1'h0},
    {1'h0, 8'h11, 5'h00, 1'h0}, {1'h0, 8'h2a, 5'h02, 1'h0}, {1'h1, 8'h3f, 5'h00, 1'h0},
    {1'h1, 8'h04, 5'h00, 1'h0}};
  logic clk, rstn, talk_only, tx_valid, tx_last, rx_ready, rsv, ok;
  logic [2:0] trig_mode;
  logic [7:0] tx_data, status, dio_c, dio_out, rx_data;
  logic [8:0] w;
  logic atn, ren, ifc, dav_c, nrfd_c, ndac_c, eoi_c, tx_ready, rx_valid, rx_eoi;
  logic dio_oe, eoi_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe, trig, dclr, lock;
  gpdev_pkg::gpdev_stat_t stat;
  gpdev_pkg::gpdev_ctl_t ctl;
  logic [8:0] rxq [$];
  int fails = 0, total_checks = 0, ntrig = 0, nclr = 0, n, c0;
  // Open-collector lines: asserted if any party pulls
  wire logic bdav = dav_c | dav_oe;
  wire logic bnrfd = nrfd_c | nrfd_oe;
  wire logic bndac = ndac_c | ndac_oe;
  wire logic beoi = eoi_c | eoi_oe;
  wire logic [7:0] bdio = dio_c | (dio_oe ? dio_out : 8'h00);
  assign ctl = {atn, ren, ifc, bdav, bnrfd, bndac};

  gpdev_core uut (.i_clk(clk), .i_resetn(rstn), .i_my_addr(MY), .i_talk_only(talk_only),
    .i_trig_mode(trig_mode), .i_bus_ctl(ctl), .i_bus_eoi(beoi), .i_bus_dio(bdio),
    .o_dio_out(dio_out), .o_dio_oe(dio_oe), .o_eoi_oe(eoi_oe), .o_dav_oe(dav_oe),
    .o_nrfd_oe(nrfd_oe), .o_ndac_oe(ndac_oe), .o_srq_oe(srq_oe), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
    .i_status_byte(status), .i_rsv(rsv), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_eoi(rx_eoi), .i_rx_ready(rx_ready), .o_trigger(trig), .o_dev_clear(dclr),
    .o_panel_lock(lock), .o_stat(stat));
  gpdev_ctrl ctl_m (.i_clk(clk), .i_dav(bdav), .i_nrfd(bnrfd), .i_ndac(bndac),
    .i_eoi(beoi), .i_dio(bdio), .o_atn(atn), .o_ren(ren), .o_ifc(ifc), .o_dav(dav_c),
    .o_nrfd(nrfd_c), .o_ndac(ndac_c), .o_eoi(eoi_c), .o_dio(dio_c));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Delivered listener words and event pulses
  always @(posedge clk) begin
    if (rx_valid === 1'h1 && rx_ready === 1'h1)
      rxq.push_back({rx_eoi, rx_data});
    ntrig += (trig === 1'h1);
    nclr += (dclr === 1'h1);
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    ctl_m.send(b, 1'h1, 1'h0, ok);
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Word into the talker buffer; gives up after a bounded wait
  task automatic push(input logic [7:0] b, input logic l);
    int k = 0;
    @(posedge clk) #1;
    {tx_valid, tx_last, tx_data} = {1'h1, l, b};
    do begin
      @(posedge clk);
      k++;
    end while (tx_ready !== 1'h1 && k < 50);
    #1 tx_valid = 1'h0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Run needs under 10k cycles; allow six times that
  initial begin
    #1500000;
    fails++;
    give_verdict();
  end

  initial begin
    {rstn, talk_only, tx_valid, tx_last, rx_ready, rsv, trig_mode} = 9'h000;
    {tx_data, status} = 16'h00a5;
    repeat (16) @(posedge clk);
    #1 rstn = 1'h1;
    check("state after reset", stat, 5'h00);
    check("drives after reset", {dio_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe}, 5'h00);
    foreach (ROWS[i]) begin
      ctl_m.set_ren(ROWS[i].ren);
      c0 = nclr;
      cmd(ROWS[i].cmd);
      check("state", stat, ROWS[i].st);
      check("panel lock", lock, ROWS[i].st[3]);
      check("clear pulses", nclr - c0, ROWS[i].clr);
    end
    // Every trigger mode, addressed each time
    for (int m = 0; m < 8; m++) begin
      trig_mode = 3'(m);
      c0 = ntrig;
      cmd({3'h1, MY});
      cmd({1'h0, gpdev_pkg::CMD_GET});
      check("trigger", ntrig - c0, 3'(m) == gpdev_pkg::TRIG_BUS_A
        || 3'(m) == gpdev_pkg::TRIG_BUS_B);
    end
    // Own listen address sent as data must not address
    cmd(8'h3f);
    ctl_m.send({3'h1, MY}, 1'h0, 1'h0, ok);
    repeat (8) @(posedge clk);
    check("listen from data", stat.listen, 1'h0);
    check("data while idle", rxq.size(), 0);
    // Fill the listener buffer until refused, then drain
    cmd({3'h1, MY});
    n = 0;
    ok = 1'h1;
    while (ok && n < 8) begin
      ctl_m.send(8'h30 + 8'(n), 1'h0, 1'h0, ok);
      n += ok;
    end
    check("words held", n, gpdev_pkg::FIFO_DEPTH);
    #1 rx_ready = 1'h1;
    ctl_m.send(8'h30 + 8'(n), 1'h0, 1'h1, ok);
    repeat (10) @(posedge clk);
    check("words out", rxq.size(), n + 1);
    foreach (rxq[i]) check("rx word", rxq[i], {i == n, 8'h30 + 8'(i)});
    // Talker buffer filled while unaddressed, then sent
    cmd(8'h3f);
    for (int i = 0; i < 4; i++) push(8'hc0 + 8'(i), i == 3);
    check("talker buffer full", tx_ready, 1'h0);
    cmd({3'h2, MY});
    for (int i = 0; i < 4; i++) begin
      ctl_m.recv(w);
      check("talker byte", w, {i == 3, 8'hc0 + 8'(i)});
    end
    cmd(8'h5f);
    talk_only = 1'h1;
    push(8'h5a, 1'h1);
    ctl_m.recv(w);
    check("talk-only byte", w, 9'h15a);
    // Serial poll with service requested
    talk_only = 1'h0;
    rsv = 1'h1;
    cmd({1'h0, gpdev_pkg::CMD_SPE});
    check("request line", srq_oe, 1'h1);
    cmd({3'h2, MY});
    ctl_m.recv(w);
    check("status byte", w, {1'h1, status[7], rsv, status[5:0]});
    repeat (4) @(posedge clk);
    check("request after poll", srq_oe, 1'h0);
    cmd({1'h0, gpdev_pkg::CMD_SPD});
    #1 rsv = 1'h0;
    // Interface clear while remote and listening
    cmd({3'h1, MY});
    ctl_m.clear_bus();
    repeat (4) @(posedge clk);
    check("state after clear", stat, 5'h00);
    give_verdict();
  end
endmodule // gpdev_test

bind gpdev_core gpdev_core_sva chk (.i_clk, .i_resetn, .i_talk_only, .i_trig_mode,
  .i_bus_ctl, .i_rsv, .o_dio_oe, .o_dav_oe, .o_nrfd_oe, .o_ndac_oe, .o_srq_oe,
  .o_trigger, .o_panel_lock, .o_stat);
`default_nettype wire
